// File: rtl/psw_watchdog.sv
/*
 * psw_watchdog: system watchdog with register file, kick paths,
 * half-period warning, retry counter and shutdown sequencing.
 * assumes: a host register port already decoded from the two-wire
 * interface; power manager pulses cold_boot and wake_req.
 */
`timescale 1ns/1ps
`default_nettype none
module psw_watchdog
    import psw_pkg::*;
#(
    parameter int PERIOD_TICKS = psw_pkg::PERIOD_BASE,
    parameter int OSC_DIV      = psw_pkg::INT_OSC_DIV
)(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       reg_wr,         // host write strobe
    input  wire logic       reg_rd,         // host read strobe
    input  wire logic [7:0] reg_addr,       // host address
    input  wire logic [7:0] reg_wdata,      // host write data
    output logic      [7:0] reg_rdata,      // registered read data
    input  wire logic       xtal_clk_pin,   // crystal 32 kHz
    input  wire logic       xtal_ok_pin,    // crystal running
    input  wire logic       kick_pin_input, // first_gp_pin
    input  wire logic       kick_pin_en,    // pin set as kick input
    input  wire logic       kick_level_mode,
    input  wire logic       lock_bypass,    // one-time option
    input  wire logic       sec_reset_en,   // gp pin as sequenced reset
    input  wire logic       cold_boot,      // pulse: cold start
    input  wire logic       wake_req,       // pulse: restart request
    output logic            run_mode,       // run mode reached
    output logic            deep_off_mode,  // in deep off
    output logic            sec_reset_out,  // secondary reset
    output logic            irq_n           // warning interrupt
);
    import psw_pkg::*;
    // ----------------------------------------
    // state and storage
    // ----------------------------------------
    psw_state_e          state_r, state_nxt;
    logic [CNT_W-1:0]    cnt_r;          // ticks since last kick
    logic [CNT_W-1:0]    seq_r;          // power-down sequence ticks
    logic                fault_r;        // wdog_fault_flag
    logic                warn_ev_r;      // wdog_warn_event
    logic                warned_r;       // warning given this period
    logic [7:0]          mask_r;         // interrupt mask register
    logic [7:0]          cfg_r;          // system config register
    logic [SCALE_W-1:0]  scale_r;        // wdog_period_select
    logic [RETRY_W-1:0]  retry_r;        // remaining retries
    logic                slow_tick;
    logic                pin_rise, pin_level;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    psw_clk_sel #(.DIV(OSC_DIV)) u_clk_sel (
        .core_clk     (core_clk),
        .rst          (rst),
        .xtal_clk_pin (xtal_clk_pin),
        .xtal_ok_pin  (xtal_ok_pin),
        .slow_tick    (slow_tick)
    );

    psw_kick_in u_kick_in (
        .core_clk       (core_clk),
        .rst            (rst),
        .kick_pin_input (kick_pin_input),
        .kick_rise      (pin_rise),
        .kick_level     (pin_level)
    );

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire wr_fault  = reg_wr & (reg_addr == FAULT_RECORD_OFS);
    wire wr_event  = reg_wr & (reg_addr == EVENT_FLAGS_OFS);
    wire wr_mask   = reg_wr & (reg_addr == IRQ_MASK_OFS);
    wire wr_cfg    = reg_wr & (reg_addr == SYS_CFG_OFS);
    wire wr_period = reg_wr & (reg_addr == PERIOD_CFG_OFS);
    wire wr_cmd    = reg_wr & (reg_addr == SYS_CMD_OFS);
    wire armed     = (state_r == PSW_WAIT) | (state_r == PSW_RUN);
    wire wdg_on    = (scale_r != SCALE_OFF);
    // stop attempt while armed is dropped unless bypassed
    wire scale_ok  = wr_period & ~(armed & wdg_on & ~lock_bypass &
                     (reg_wdata[SCALE_W-1:0] == SCALE_OFF));

    // ----------------------------------------
    // period and kick qualification
    // ----------------------------------------
    wire [CNT_W-1:0] period  = CNT_W'(PERIOD_TICKS) << (scale_r - 3'h1);
    wire [CNT_W-1:0] half    = period >> 1;
    wire             min_ok  = (cnt_r >= CNT_W'(MIN_KICK));
    wire reg_kick  = wr_cmd & reg_wdata[KICK_BIT];
    wire pin_kick  = kick_pin_en & (kick_level_mode ? pin_level
                     : (pin_rise & min_ok));
    wire kick      = armed & (reg_kick | pin_kick);
    wire warn_hit  = armed & wdg_on & slow_tick & ~kick & ~warned_r &
                     (cnt_r + CNT_W'(1) >= half);
    wire expire    = armed & wdg_on & slow_tick & ~kick &
                     (cnt_r + CNT_W'(1) >= period);
    wire seq_done  = slow_tick & (seq_r == CNT_W'(SEQ_TICKS - 1));

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            PSW_OFF:
            begin
                // cold start arms; restart only with retries left
                if (cold_boot | (wake_req & (retry_r != '0)))
                    state_nxt = PSW_WAIT;
            end
            PSW_WAIT:
            begin
                if (expire)
                    state_nxt = PSW_SHUT;
                else if (kick | ~wdg_on)
                    state_nxt = PSW_RUN;
            end
            PSW_RUN:
            begin
                if (expire)
                    state_nxt = PSW_SHUT;
            end
            PSW_SHUT:
            begin
                if (seq_done)
                    state_nxt = PSW_OFF;
            end
            default:
                state_nxt = PSW_OFF;
        endcase
        if (cold_boot)
            state_nxt = PSW_WAIT;
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_r <= PSW_OFF;
        else
            state_r <= state_nxt;
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_r    <= '0;
            warned_r <= 1'b0;
            seq_r    <= '0;
        end
        else
        begin
            if (kick | ~armed | cold_boot)
            begin
                cnt_r    <= '0;
                warned_r <= 1'b0;
            end
            else if (slow_tick & wdg_on)
            begin
                cnt_r <= cnt_r + CNT_W'(1);
                if (warn_hit)
                    warned_r <= 1'b1;
            end
            if (state_r != PSW_SHUT)
                seq_r <= '0;
            else if (slow_tick)
                seq_r <= seq_r + CNT_W'(1);
        end
    end

    // retry counter
    always_ff @(posedge core_clk)
    begin
        if (rst)
            retry_r <= '0;
        else if (cold_boot)
            retry_r <= cfg_r[RETRY_LSB +: RETRY_W];
        else if (expire & (retry_r != '0))
            retry_r <= retry_r - RETRY_W'(1);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // sticky flags: hardware set wins over write-one clear
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            fault_r   <= 1'b0;
            warn_ev_r <= 1'b0;
        end
        else
        begin
            if (expire)
                fault_r <= 1'b1;
            else if (wr_fault & reg_wdata[FAULT_BIT])
                fault_r <= 1'b0;
            if (warn_hit)
                warn_ev_r <= 1'b1;
            else if (wr_event & reg_wdata[WARN_BIT])
                warn_ev_r <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mask_r  <= IRQ_MASK_RST;
            cfg_r   <= SYS_CFG_RST;
            scale_r <= SCALE_RST;
        end
        else
        begin
            if (wr_mask)
                mask_r <= reg_wdata;
            if (wr_cfg)
                cfg_r <= reg_wdata;
            if (scale_ok)
                scale_r <= reg_wdata[SCALE_W-1:0];
        end
    end

    // read mux, answered one cycle after the strobe
    wire [7:0] rd_mux =
        (reg_addr == FAULT_RECORD_OFS) ? 8'(fault_r) << FAULT_BIT :
        (reg_addr == EVENT_FLAGS_OFS)  ? 8'(warn_ev_r) << WARN_BIT :
        (reg_addr == IRQ_MASK_OFS)     ? mask_r :
        (reg_addr == SYS_CFG_OFS)      ? cfg_r :
        (reg_addr == PERIOD_CFG_OFS)   ? 8'(scale_r) : 8'h00;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_mux;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign run_mode      = (state_r == PSW_RUN);
    assign deep_off_mode = (state_r == PSW_OFF);
    assign sec_reset_out = sec_reset_en & (state_r == PSW_SHUT);
    assign irq_n = ~(warn_ev_r & ~mask_r[WARN_BIT]);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    timeout_fault_a: assert property (expire && !cold_boot |=> fault_r && state_r == PSW_SHUT)
        else $error("timeout without fault and shutdown");
    stop_lock_a: assert property (armed && wdg_on && !lock_bypass && wr_period
        && reg_wdata[SCALE_W-1:0] == SCALE_OFF |=> wdg_on)
        else $error("watchdog stopped while locked");
    first_kick_a: assert property (state_r == PSW_WAIT && kick && !expire
        && !cold_boot |=> run_mode)
        else $error("first kick did not enter run");
    wait_norun_a: assert property (!run_mode && !(state_r == PSW_WAIT && (kick || !wdg_on))
        |=> !run_mode)
        else $error("run mode before first kick");
    warn_irq_a: assert property (warn_hit && !mask_r[WARN_BIT] |=> !irq_n)
        else $error("warning did not raise interrupt");
    reg_kick_a: assert property (armed && reg_kick && !cold_boot
        |=> cnt_r == '0 && !warned_r)
        else $error("register kick did not restart");
    pin_kick_a: assert property (armed && kick_pin_en && !kick_level_mode
        && pin_rise && min_ok |=> cnt_r == '0)
        else $error("pin kick ignored");
    level_hold_a: assert property (state_r == PSW_RUN && kick_pin_en
        && kick_level_mode && pin_level && !cold_boot |=> state_r == PSW_RUN)
        else $error("held kick level did not prevent timeout");
    sec_reset_a: assert property (expire && sec_reset_en && !cold_boot
        |=> sec_reset_out)
        else $error("secondary reset missing in shutdown");
    retry_dec_a: assert property (expire && retry_r != '0 && !cold_boot
        |=> retry_r == $past(retry_r) - RETRY_W'(1))
        else $error("retry not decremented");
    retry_zero_a: assert property (deep_off_mode && retry_r == '0 && !cold_boot
        |=> deep_off_mode)
        else $error("restart with no retries left");
    retry_load_a: assert property (cold_boot
        |=> retry_r == $past(cfg_r[RETRY_LSB +: RETRY_W]))
        else $error("retries not loaded at cold boot");

    cov_boot_c:    cover property (cold_boot ##[1:20] run_mode);
    cov_warn_c:    cover property (warn_hit);
    cov_timeout_c: cover property (expire ##1 state_r == PSW_SHUT);
    cov_restart_c: cover property (deep_off_mode && wake_req && retry_r != '0);
endmodule : psw_watchdog
`default_nettype wire

// File: rtl/psw_pkg.sv
/*
 * psw_pkg: register map, field positions, reset values, states and
 * timing constants of the system watchdog.
 * assumes: one 125 MHz core clock; registers are 8 bits wide.
 */
package psw_pkg;
    // ----------------------------------------
    // register offsets (8-bit host address)
    // ----------------------------------------
    localparam logic [7:0] FAULT_RECORD_OFS = 8'h05;
    localparam logic [7:0] EVENT_FLAGS_OFS  = 8'h06;
    localparam logic [7:0] IRQ_MASK_OFS     = 8'h0a;
    localparam logic [7:0] SYS_CFG_OFS      = 8'h0f;
    localparam logic [7:0] PERIOD_CFG_OFS   = 8'h11;
    localparam logic [7:0] SYS_CMD_OFS      = 8'h13;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int FAULT_BIT   = 0;  // wdog_fault_flag
    localparam int WARN_BIT    = 3;  // wdog_warn_event / wdog_warn_mask
    localparam int RETRY_LSB   = 5;  // retry_limit_field [6:5]
    localparam int RETRY_W     = 2;
    localparam int SCALE_W     = 3;  // wdog_period_select [2:0]
    localparam int KICK_BIT    = 0;  // kick bit of command register
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] IRQ_MASK_RST   = 8'h00;
    localparam logic [7:0] SYS_CFG_RST    = 8'h60;
    localparam logic [2:0] SCALE_RST      = 3'h1;
    localparam logic [2:0] SCALE_OFF      = 3'h0;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ      = 125;
    localparam int SLOW_KHZ     = 32;                       // slow tick rate
    localparam int INT_OSC_DIV  = (CLK_MHZ * 1000) / SLOW_KHZ;
    localparam int PERIOD_BASE  = 2048;   // slow ticks at select 1
    localparam int MIN_KICK     = 8;      // slow ticks, edge mode only
    localparam int SEQ_TICKS    = 16;     // power-down sequence length
    localparam int CNT_W        = 24;
    // ----------------------------------------
    // watchdog states
    // ----------------------------------------
    typedef enum logic [1:0] {
        PSW_OFF,    // deep off mode, watchdog idle
        PSW_WAIT,   // entering run mode, waiting first kick
        PSW_RUN,    // run mode, watchdog armed
        PSW_SHUT    // power-down sequence after timeout
    } psw_state_e;
endpackage : psw_pkg

// File: rtl/psw_clk_sel.sv
/*
 * psw_clk_sel: picks the slow counting clock without software help.
 * assumes: xtal_clk_pin is an asynchronous 32 kHz square wave and
 * xtal_ok_pin an asynchronous level from the crystal monitor.
 */
`timescale 1ns/1ps
`default_nettype none
module psw_clk_sel
    import psw_pkg::*;
#(
    parameter int DIV = psw_pkg::INT_OSC_DIV
)(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic xtal_clk_pin,
    input  wire logic xtal_ok_pin,
    output logic      slow_tick
);
    import psw_pkg::*;
    // ----------------------------------------
    // synchronisers and edge detect
    // ----------------------------------------
    logic [1:0] xclk_sync_r;   // crystal clock sync pair
    logic [1:0] xok_sync_r;    // crystal good sync pair
    logic       xclk_prev_r;   // last synced crystal level
    logic [15:0] div_r;        // internal slow clock divider
    logic       tick_prev_r;   // tick given last cycle
    wire        xtal_rise = xclk_sync_r[1] & ~xclk_prev_r;
    // raw pick; a source swap may line up two ticks back to back
    wire        tick_raw  = xok_sync_r[1] ? xtal_rise : div_end;
    wire        div_end   = (div_r == 16'(DIV - 1));

    // sample pins, run divider
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            xclk_sync_r <= 2'h0;
            xok_sync_r  <= 2'h0;
            xclk_prev_r <= 1'b0;
            div_r       <= 16'h0;
            tick_prev_r <= 1'b0;
        end
        else
        begin
            xclk_sync_r <= {xclk_sync_r[0], xtal_clk_pin};
            xok_sync_r  <= {xok_sync_r[0], xtal_ok_pin};
            xclk_prev_r <= xclk_sync_r[1];
            div_r       <= div_end ? 16'h0 : div_r + 16'h1;
            tick_prev_r <= slow_tick;
        end
    end

    // automatic choice of source
    always_comb
    begin
        // swallow a tick right after another, so back-to-back ticks from a swap count once
        slow_tick = tick_raw & ~tick_prev_r;
    end

    tick_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        slow_tick |=> !slow_tick) else $error("slow tick longer than one cycle");
endmodule : psw_clk_sel
`default_nettype wire

// File: rtl/psw_kick_in.sv
/*
 * psw_kick_in: conditions the kick pin.
 * assumes: kick_pin_input is asynchronous, active high.
 */
`timescale 1ns/1ps
`default_nettype none
module psw_kick_in (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic kick_pin_input,
    output logic      kick_rise,
    output logic      kick_level
);
    // ----------------------------------------
    // sync and edge
    // ----------------------------------------
    logic [1:0] sync_r;   // two-stage synchroniser
    logic       prev_r;   // previous synced level

    // sample the pin
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sync_r <= 2'h0;
            prev_r <= 1'b0;
        end
        else
        begin
            sync_r <= {sync_r[0], kick_pin_input};
            prev_r <= sync_r[1];
        end
    end

    assign kick_rise  = sync_r[1] & ~prev_r;   // one-cycle pulse
    assign kick_level = sync_r[1];             // held level
endmodule : psw_kick_in
`default_nettype wire

// File: dv/psw_host_model.sv
/*
 * psw_host_model: host processor side of the kick pin.
 * assumes: bench strobes pulse_req for one cycle; hold_req is a level.
 */
`timescale 1ns/1ps
`default_nettype none
module psw_host_model (
    input  wire logic core_clk,
    input  wire logic pulse_req,
    input  wire logic hold_req,
    output logic      kick_pin_input
);
    logic [2:0] width_r = 3'h0; // cycles left of the pulse
    // ----------------------------------------
    // pulse stretcher, outlasts the synchroniser
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (pulse_req)
            width_r <= 3'h4;
        else if (width_r != 3'h0)
            width_r <= width_r - 3'h1;
    end
    // held level or pulse drives the pin
    assign kick_pin_input = hold_req | (width_r != 3'h0);
endmodule : psw_host_model
`default_nettype wire

// File: dv/psw_watchdog_tb.sv
/*
 * psw_watchdog_tb: self-checking bench of the system watchdog.
 * assumes: short counts (8 tick period, divide by 4), host model on pin.
 */
`timescale 1ns/1ps
`default_nettype none
module psw_watchdog_tb;
    import psw_pkg::*;
    localparam int PT = 8; // period ticks at select 1
    localparam int DV = 4; // core cycles per internal tick
    logic       core_clk = 1'b0, rst = 1'b1, xtal_clk_pin = 1'b0;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, xtal_ok_pin = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
    logic       kick_pin_en = 1'b0, kick_level_mode = 1'b0;
    logic       lock_bypass = 1'b0, sec_reset_en = 1'b1;
    logic       cold_boot = 1'b0, wake_req = 1'b0;
    logic       pulse_req = 1'b0, hold_req = 1'b0, kick_pin_input;
    logic       run_mode, deep_off_mode, sec_reset_out, irq_n;
    int         bad_count = 0, comparisons = 0, cycle_count = 0;
    int         seed, gap;
    // ----------------------------------------
    // clocks and hang guard
    // ----------------------------------------
    always #4 core_clk = ~core_clk;
    always #24 xtal_clk_pin = ~xtal_clk_pin; // fast crystal stand-in
    always @(posedge core_clk)
    begin
        cycle_count++;
        if (cycle_count == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    psw_watchdog #(.PERIOD_TICKS(PT), .OSC_DIV(DV)) dut (
        .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .xtal_clk_pin(xtal_clk_pin), .xtal_ok_pin(xtal_ok_pin),
        .kick_pin_input(kick_pin_input), .kick_pin_en(kick_pin_en),
        .kick_level_mode(kick_level_mode), .lock_bypass(lock_bypass),
        .sec_reset_en(sec_reset_en), .cold_boot(cold_boot), .wake_req(wake_req),
        .run_mode(run_mode), .deep_off_mode(deep_off_mode),
        .sec_reset_out(sec_reset_out), .irq_n(irq_n));
    psw_host_model host (
        .core_clk(core_clk), .pulse_req(pulse_req), .hold_req(hold_req),
        .kick_pin_input(kick_pin_input));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // worst-case core cycles for n ticks at a select, with sync slack
    function automatic int lim(input int sel, input int n);
        return ((PT << (sel - 1)) * n / PT) * 6 + 12;
    endfunction : lim
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic check_bit(input string nm, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %b seen %b", nm, exp, got);
        end
    endtask : check_bit
    task automatic check_byte(input string nm, input logic [7:0] exp,
                              input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : check_byte
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : reg_write
    task automatic expect_reg(input string nm, input logic [7:0] a,
                              input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        tick(1);
        check_byte(nm, exp, reg_rdata);
    endtask : expect_reg
    // waits for a level under a bound, then compares it
    task automatic wait_for(input string nm, ref logic sig, input logic lvl,
                            input int n);
        int k;
        k = 0;
        while (sig !== lvl && k < n)
        begin
            tick(1);
            k++;
        end
        check_bit(nm, lvl, sig);
    endtask : wait_for
    task automatic tally_and_finish();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        seed = 32'h3ccd396f;
        tick(6);
        rst = 1'b0;
        // reset values, write-only and unmapped places
        check_bit("deep_off_mode", 1'b1, deep_off_mode);
        check_bit("irq_n", 1'b1, irq_n);
        expect_reg("mask", IRQ_MASK_OFS, IRQ_MASK_RST);
        expect_reg("sys_cfg", SYS_CFG_OFS, SYS_CFG_RST);
        expect_reg("period", PERIOD_CFG_OFS, {5'h00, SCALE_RST});
        expect_reg("fault", FAULT_RECORD_OFS, 8'h00);
        expect_reg("command", SYS_CMD_OFS, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            rd = 8'($random(seed));
            reg_write(IRQ_MASK_OFS, rd);
            expect_reg("mask rw", IRQ_MASK_OFS, rd);
            reg_write(8'h20, rd);
            expect_reg("unmapped", 8'h20, 8'h00);
        end
        reg_write(IRQ_MASK_OFS, 8'h00);
        // cold boot waits for the first kick, two retries
        reg_write(SYS_CFG_OFS, 8'h40);
        cold_boot = 1'b1;
        tick(1);
        cold_boot = 1'b0;
        tick(4);
        check_bit("run before kick", 1'b0, run_mode);
        reg_write(SYS_CMD_OFS, 8'h01);
        check_bit("run after kick", 1'b1, run_mode);
        // random register kicks inside the half period
        for (int i = 0; i < 40; i++)
        begin
            gap = 1 + ({$random(seed)} % 8);
            tick(gap);
            reg_write(SYS_CMD_OFS, 8'h01);
            check_bit("run kept", 1'b1, run_mode);
            check_bit("no warn", 1'b1, irq_n);
        end
        // stop attempt is refused unless bypassed
        reg_write(PERIOD_CFG_OFS, 8'h00);
        expect_reg("locked select", PERIOD_CFG_OFS, 8'h01);
        lock_bypass = 1'b1;
        reg_write(PERIOD_CFG_OFS, 8'h00);
        expect_reg("bypassed select", PERIOD_CFG_OFS, 8'h00);
        reg_write(PERIOD_CFG_OFS, 8'h01);
        lock_bypass = 1'b0;
        reg_write(SYS_CMD_OFS, 8'h01);
        // half period warning, clear, then masked
        wait_for("warn irq", irq_n, 1'b0, lim(1, 4));
        expect_reg("warn flag", EVENT_FLAGS_OFS, 8'h08);
        reg_write(SYS_CMD_OFS, 8'h01);
        reg_write(EVENT_FLAGS_OFS, 8'h08);
        check_bit("warn cleared", 1'b1, irq_n);
        reg_write(IRQ_MASK_OFS, 8'h08);
        reg_write(SYS_CMD_OFS, 8'h01);
        tick(22);
        check_bit("masked irq", 1'b1, irq_n);
        expect_reg("masked flag", EVENT_FLAGS_OFS, 8'h08);
        // timeout: shutdown with secondary reset, then off
        wait_for("shutdown", run_mode, 1'b0, lim(1, 8));
        check_bit("sec reset", 1'b1, sec_reset_out);
        wait_for("deep off", deep_off_mode, 1'b1, lim(1, 16));
        check_bit("sec reset off", 1'b0, sec_reset_out);
        expect_reg("fault set", FAULT_RECORD_OFS, 8'h01);
        reg_write(FAULT_RECORD_OFS, 8'h01);
        expect_reg("fault clr", FAULT_RECORD_OFS, 8'h00);
        // one retry left: restart, crystal ticks this time
        wake_req = 1'b1;
        tick(1);
        wake_req = 1'b0;
        tick(2);
        check_bit("restart", 1'b0, deep_off_mode);
        reg_write(SYS_CMD_OFS, 8'h01);
        reg_write(EVENT_FLAGS_OFS, 8'h08);
        reg_write(IRQ_MASK_OFS, 8'h00);
        xtal_ok_pin = 1'b1;
        wait_for("xtal warn", irq_n, 1'b0, lim(1, 4));
        // internal ticks would have timed out by now, crystal ticks not
        tick(18);
        check_bit("xtal pace", 1'b1, run_mode);
        wait_for("xtal timeout", run_mode, 1'b0, lim(1, 4));
        wait_for("off again", deep_off_mode, 1'b1, lim(1, 16));
        xtal_ok_pin = 1'b0;
        wake_req = 1'b1;
        tick(1);
        wake_req = 1'b0;
        tick(4);
        check_bit("no retries", 1'b1, deep_off_mode);
        // pin kicks, edge mode then level mode
        reg_write(PERIOD_CFG_OFS, 8'h03);
        kick_pin_en = 1'b1;
        cold_boot = 1'b1;
        tick(1);
        cold_boot = 1'b0;
        reg_write(EVENT_FLAGS_OFS, 8'h08);
        // edge kicks are ignored until MIN_KICK ticks have passed
        tick(DV * MIN_KICK + 8);
        pulse_req = 1'b1;
        tick(1);
        pulse_req = 1'b0;
        tick(8);
        check_bit("pin first kick", 1'b1, run_mode);
        for (int i = 0; i < 6; i++)
        begin
            gap = 40 + ({$random(seed)} % 12);
            tick(gap);
            pulse_req = 1'b1;
            tick(1);
            pulse_req = 1'b0;
            check_bit("pin kick", 1'b1, run_mode);
        end
        kick_level_mode = 1'b1;
        hold_req = 1'b1;
        tick(300);
        check_bit("held run", 1'b1, run_mode);
        check_bit("held no warn", 1'b1, irq_n);
        hold_req = 1'b0;
        kick_level_mode = 1'b0;
        sec_reset_en = 1'b0;
        wait_for("pin starve", run_mode, 1'b0, lim(3, 40));
        check_bit("no sec reset", 1'b0, sec_reset_out);
        tally_and_finish();
    end
endmodule : psw_watchdog_tb
`default_nettype wire
